// *** pkg/sleep_ctrl_pkg.sv ***
// Notes on behaviour
// - sleep starts only if sleep enable is one when the sleep instruction executes
// - interrupt wake stalls the cpu four cycles beyond start-up, then runs the handler
// - register file and sram contents are kept across sleep and wake-up
// - reset during sleep wakes the device and starts at the reset vector
// - control register: enable bit 5, mode bits 4..2 ordered one,zero,two; reset zero
// - mode codes: 000 idle, 001 adc quiet, 010 down, 011 save, 110/111 standby
// - standby modes only offered when a crystal or resonator clock is selected
// - idle stops only cpu and flash clocks; peripherals keep running
// - entering idle or adc quiet mode with adc enabled starts a conversion
// - adc quiet mode stops io, cpu and flash clocks
// - adc quiet wakes on adc done, resets, address match, timer0, spm, ext lines
// - power-down stops oscillator and all generated clocks
// - power-down wakes on resets, address match, upper level or lower ext interrupt
// - wake from power-down waits the start-up period chosen by clock-select fuses
// - power-save is power-down plus async timer0 and its enabled interrupt wake
// - power-save without async timer0 leaves timer contents undefined
// - code 110 with crystal: power-down with oscillator on, wakes in six cycles
// - code 111 with crystal: power-save with oscillator on, wakes in six cycles
// - idle wakes on any interrupt; comparator disable powers down the comparator
// - main clock and async clock enables follow the per-mode table
package sleep_ctrl_pkg;
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_AUX = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int SE_POS = 5;
    localparam int SM1_POS = 4;
    localparam int SM0_POS = 3;
    localparam int SM2_POS = 2;
    localparam int AUX_AS0_POS = 0;
    localparam int AUX_ACD_POS = 1;
    localparam int AUX_ADEN_POS = 2;
    localparam int AUX_XTAL_POS = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [4:0] EXTRA_STALL = 5'h04;
    localparam logic [4:0] STANDBY_WAKE = 5'h06;
    localparam logic [4:0] STARTUP_6CK = 5'h06;
    localparam logic [4:0] STARTUP_18CK = 5'h12;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000, M_ADCNR = 3'b001, M_PDOWN = 3'b010, M_PSAVE = 3'b011,
        M_RSV4 = 3'b100, M_RSV5 = 3'b101, M_STBY = 3'b110, M_XSTBY = 3'b111
    } mode_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00, ST_SLEEP = 2'b01, ST_WAKE = 2'b10
    } state_t;
endpackage

// *** rtl/sleep_mode_controller.sv ***
`timescale 1ns/1ps
module sleep_mode_controller (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // global
    input wire logic clk_en,
    // cpu side
    input wire logic sleep_instr,
    input wire logic sys_reset_req,
    input wire logic global_irq_en,
    // wake sources
    input wire logic [3:0] ext_irq_lower,
    input wire logic [3:0] ext_irq_upper,
    input wire logic twi_addr_match,
    input wire logic timer0_ovf_irq,
    input wire logic timer0_cmp_irq,
    input wire logic [1:0] timer_irq_mask,
    input wire logic adc_done_irq,
    input wire logic spm_ready_irq,
    input wire logic other_io_irq,
    // start-up fuse choice
    input wire logic [1:0] startup_sel,
    // clock gates and status
    output logic cpu_clock_domain,
    output logic flash_clock_domain,
    output logic io_clock_domain,
    output logic converter_clock_domain,
    output logic async_clock_domain,
    output logic main_osc_en,
    output logic timer_osc_en,
    // status and handshake
    output logic comparator_power,
    output logic adc_start,
    output logic cpu_stall,
    output logic wake_irq,
    output logic wake_reset,
    output logic sleeping
);
    typedef struct packed {
        // software registers
        logic [7:0] control;
        logic [7:0] aux;
        // sequencer
        sleep_ctrl_pkg::state_t state;
        sleep_ctrl_pkg::mode_t mode;
        logic [4:0] count;
        logic by_reset;
        // one-cycle pulses
        logic adc_start;
        logic wake_irq;
        logic wake_reset;
        // bus read data
        logic [31:0] rdata;
    } regs_t;

    // state and its next value
    regs_t r;
    regs_t next_r;
    // bus decode
    logic wr;
    logic rd;
    // mode decode
    logic [2:0] req_code;
    logic [2:0] eff_code;
    logic xtal;
    logic as0;
    // wake decode
    logic irq_wake;
    logic t0_wake;
    logic [1:0] ck;

    // gather mode bits in (bit2,bit1,bit0) order
    function automatic logic [2:0] mode_code(input logic [7:0] c);
        mode_code = {c[sleep_ctrl_pkg::SM2_POS], c[sleep_ctrl_pkg::SM1_POS], c[sleep_ctrl_pkg::SM0_POS]};
    endfunction

    // register read decode; unmapped offsets read as zero with no bus error
    function automatic logic [31:0] read_word(input logic [11:0] a, input regs_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == sleep_ctrl_pkg::ADDR_CONTROL) begin
            w[7:0] = s.control;
        end else if (a == sleep_ctrl_pkg::ADDR_AUX) begin
            w[7:0] = s.aux;
        end else if (a == sleep_ctrl_pkg::ADDR_STATUS) begin
            // status: sleeping, effective mode, last wake cause
            w[0] = s.state == sleep_ctrl_pkg::ST_SLEEP;
            w[3:1] = s.mode;
            w[4] = s.by_reset;
        end
        read_word = w;
    endfunction

    // stall before the core restarts: clock restart time plus interrupt entry
    function automatic logic [4:0] wake_count(input sleep_ctrl_pkg::mode_t m, input logic [1:0] sel,
                                              input logic by_rst);
        logic [4:0] base;
        base = 5'h00;
        if (m == sleep_ctrl_pkg::M_STBY || m == sleep_ctrl_pkg::M_XSTBY) begin
            base = sleep_ctrl_pkg::STANDBY_WAKE;
        end else if (m == sleep_ctrl_pkg::M_PDOWN || m == sleep_ctrl_pkg::M_PSAVE) begin
            // start-up from fuse choice; the clock must restart and settle
            if (sel == 2'b00) begin
                base = sleep_ctrl_pkg::STARTUP_6CK;
            end else begin
                base = sleep_ctrl_pkg::STARTUP_18CK;
            end
        end
        // a reset restarts at its vector, with no interrupt entry
        if (by_rst) begin
            wake_count = base;
        end else begin
            wake_count = base + sleep_ctrl_pkg::EXTRA_STALL;
        end
    endfunction

    // write taken in the access phase, read captured in the setup phase
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    // no wait states: every access ends after one access cycle
    assign pready = 1'b1;
    // aux bits used by the mode logic
    assign xtal = r.aux[sleep_ctrl_pkg::AUX_XTAL_POS];
    assign as0 = r.aux[sleep_ctrl_pkg::AUX_AS0_POS];
    // requested mode straight from the control bits
    assign req_code = mode_code(r.control);
    // core and flash clocks gate together while asleep
    assign ck = (r.state == sleep_ctrl_pkg::ST_SLEEP) ? 2'b00 : 2'b11;

    // reserved codes fall back to idle; standby codes need a crystal
    always_comb begin
        eff_code = req_code;
        case (req_code)
            sleep_ctrl_pkg::M_RSV4, sleep_ctrl_pkg::M_RSV5: begin
                // no defined behaviour, so the shallowest mode is used
                eff_code = sleep_ctrl_pkg::M_IDLE;
            end
            sleep_ctrl_pkg::M_STBY: begin
                // without a crystal the oscillator cannot be kept, so 110 falls to down
                if (!xtal) begin
                    eff_code = sleep_ctrl_pkg::M_PDOWN;
                end
            end
            sleep_ctrl_pkg::M_XSTBY: begin
                // likewise 111 falls to power-save
                if (!xtal) begin
                    eff_code = sleep_ctrl_pkg::M_PSAVE;
                end
            end
            default: begin
                // documented codes pass unchanged
                eff_code = req_code;
            end
        endcase
    end

    // in the save modes timer0 may only wake when clocked asynchronously and unmasked
    assign t0_wake = as0 && global_irq_en && |{timer0_ovf_irq & timer_irq_mask[0],
                                               timer0_cmp_irq & timer_irq_mask[1]};

    // wake source selection per mode; ext lines and address match wake from every mode
    always_comb begin
        irq_wake = |ext_irq_lower || |ext_irq_upper || twi_addr_match;
        case (r.mode)
            sleep_ctrl_pkg::M_IDLE: begin
                // idle keeps every peripheral clocked, so any interrupt wakes
                irq_wake = irq_wake || timer0_ovf_irq || timer0_cmp_irq;
                irq_wake = irq_wake || adc_done_irq;
                irq_wake = irq_wake || spm_ready_irq;
                irq_wake = irq_wake || other_io_irq;
            end
            sleep_ctrl_pkg::M_ADCNR: begin
                // io clock is off, so other io interrupts cannot fire
                irq_wake = irq_wake || adc_done_irq;
                irq_wake = irq_wake || spm_ready_irq;
                irq_wake = irq_wake || timer0_ovf_irq || timer0_cmp_irq;
            end
            sleep_ctrl_pkg::M_PDOWN: begin
                // only asynchronous sources remain
                irq_wake = irq_wake;
            end
            sleep_ctrl_pkg::M_PSAVE: begin
                // the asynchronous timer may add its own wake
                irq_wake = irq_wake || t0_wake;
            end
            sleep_ctrl_pkg::M_STBY: begin
                // as power-down, oscillator running
                irq_wake = irq_wake;
            end
            sleep_ctrl_pkg::M_XSTBY: begin
                // as power-save, oscillator running
                irq_wake = irq_wake || t0_wake;
            end
            default: begin
                irq_wake = irq_wake;
            end
        endcase
    end

    // next state
    always_comb begin
        next_r = r;
        next_r.adc_start = 1'b0;
        next_r.wake_irq = 1'b0;
        next_r.wake_reset = 1'b0;
        // read data is captured in setup and stands through the access phase
        if (rd) begin
            next_r.rdata = read_word(paddr, r);
        end
        // writes land in the access phase; only the low byte is kept
        if (wr) begin
            if (paddr == sleep_ctrl_pkg::ADDR_CONTROL) begin
                next_r.control = pwdata[7:0];
            end else if (paddr == sleep_ctrl_pkg::ADDR_AUX) begin
                next_r.aux = pwdata[7:0];
            end
        end
        // sleep sequencer
        case (r.state)
            sleep_ctrl_pkg::ST_RUN: begin
                // an opcode without the enable bit is ignored
                if (sleep_instr && r.control[sleep_ctrl_pkg::SE_POS]) begin
                    next_r.state = sleep_ctrl_pkg::ST_SLEEP;
                    next_r.mode = sleep_ctrl_pkg::mode_t'(eff_code);
                    next_r.by_reset = 1'b0;
                    // conversion kicks off on entry to idle or adc quiet mode
                    next_r.adc_start = r.aux[sleep_ctrl_pkg::AUX_ADEN_POS]
                                       && eff_code[2:1] == 2'b00;
                end
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
                // a reset wins over an interrupt arriving in the same cycle
                if (sys_reset_req || irq_wake) begin
                    next_r.state = sleep_ctrl_pkg::ST_WAKE;
                    next_r.by_reset = sys_reset_req;
                    next_r.count = wake_count(r.mode, startup_sel, sys_reset_req);
                end
            end
            sleep_ctrl_pkg::ST_WAKE: begin
                // count down the start-up stall, then release the core with a pulse
                if (r.count <= 5'h01) begin
                    next_r.state = sleep_ctrl_pkg::ST_RUN;
                    next_r.count = 5'h00;
                    next_r.wake_irq = !r.by_reset;
                    next_r.wake_reset = r.by_reset;
                end else begin
                    next_r.count = r.count - 5'h01;
                end
            end
            default: begin
                // an unused state code recovers to run
                next_r.state = sleep_ctrl_pkg::ST_RUN;
            end
        endcase
    end

    // single state register; memory is untouched so cpu state survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // all clears, which leaves every clock domain and the main oscillator running; the timer oscillator is off
            r <= '0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // clock domain gating per mode
    always_comb begin
        cpu_clock_domain = 1'b1;
        flash_clock_domain = 1'b1;
        io_clock_domain = 1'b1;
        converter_clock_domain = 1'b1;
        async_clock_domain = 1'b1;
        main_osc_en = 1'b1;
        timer_osc_en = as0;
        if (r.state == sleep_ctrl_pkg::ST_SLEEP) begin
            cpu_clock_domain = ck[0];
            flash_clock_domain = ck[1];
            case (r.mode)
                sleep_ctrl_pkg::M_IDLE: begin
                    // only the core and flash clocks stop
                    io_clock_domain = 1'b1;
                    converter_clock_domain = 1'b1;
                    async_clock_domain = 1'b1;
                    main_osc_en = 1'b1;
                    timer_osc_en = as0;
                end
                sleep_ctrl_pkg::M_ADCNR: begin
                    // io stops so the converter sees a quiet supply
                    io_clock_domain = 1'b0;
                    converter_clock_domain = 1'b1;
                    async_clock_domain = 1'b1;
                    main_osc_en = 1'b1;
                    timer_osc_en = as0;
                end
                sleep_ctrl_pkg::M_PDOWN: begin
                    // everything but asynchronous logic stops
                    io_clock_domain = 1'b0;
                    converter_clock_domain = 1'b0;
                    async_clock_domain = 1'b0;
                    main_osc_en = 1'b0;
                    timer_osc_en = 1'b0;
                end
                sleep_ctrl_pkg::M_PSAVE: begin
                    // without the async select the timer stops and its contents are lost
                    io_clock_domain = 1'b0;
                    converter_clock_domain = 1'b0;
                    async_clock_domain = as0;
                    main_osc_en = 1'b0;
                    timer_osc_en = as0;
                end
                sleep_ctrl_pkg::M_STBY: begin
                    // oscillator kept for a fast wake
                    io_clock_domain = 1'b0;
                    converter_clock_domain = 1'b0;
                    async_clock_domain = 1'b0;
                    main_osc_en = 1'b1;
                    timer_osc_en = 1'b0;
                end
                sleep_ctrl_pkg::M_XSTBY: begin
                    // power-save with the oscillator kept running
                    io_clock_domain = 1'b0;
                    converter_clock_domain = 1'b0;
                    async_clock_domain = as0;
                    main_osc_en = 1'b1;
                    timer_osc_en = as0;
                end
                default: begin
                    // reserved codes are never stored; behave as idle
                    io_clock_domain = 1'b1;
                    converter_clock_domain = 1'b1;
                    async_clock_domain = 1'b1;
                    main_osc_en = 1'b1;
                    timer_osc_en = as0;
                end
            endcase
        end
    end

    // comparator off when disabled or in the deeper modes
    always_comb begin
        comparator_power = 1'b1;
        if (r.aux[sleep_ctrl_pkg::AUX_ACD_POS]) begin
            comparator_power = 1'b0;
        end else if (r.state == sleep_ctrl_pkg::ST_SLEEP && r.mode[2:1] != 2'b00) begin
            // deeper modes shut the comparator by themselves
            comparator_power = 1'b0;
        end
    end

    // core handshake: stalled while asleep and while waking
    assign cpu_stall = r.state != sleep_ctrl_pkg::ST_RUN;
    assign sleeping = r.state == sleep_ctrl_pkg::ST_SLEEP;
    // one-cycle pulses straight from flops
    assign adc_start = r.adc_start;
    assign wake_irq = r.wake_irq;
    assign wake_reset = r.wake_reset;
    assign prdata = r.rdata;
    assign pslverr = 1'b0;
endmodule

// *** testbench/sleep_cpu_model.sv ***
`timescale 1ns/1ps
module sleep_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the bench
    input wire logic go,
    input wire logic [3:0] delay,
    // opcode strobe toward the controller
    output logic sleep_instr
);
    logic armed;
    logic [3:0] cnt;
    // a slow core lets some cycles pass before the opcode; the strobe lasts one cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
            cnt <= 4'h0;
            sleep_instr <= 1'b0;
        end else begin
            sleep_instr <= armed && cnt == 4'h0;
            if (go) begin
                armed <= 1'b1;
                cnt <= delay;
            end else if (armed && cnt == 4'h0) begin
                armed <= 1'b0;
            end else if (armed) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// *** testbench/sleep_mode_controller_sva.sv ***
`timescale 1ns/1ps
module sleep_mode_controller_sva (
    // watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_instr,
    input wire logic cpu_clock_domain,
    input wire logic flash_clock_domain,
    input wire logic io_clock_domain,
    input wire logic converter_clock_domain,
    input wire logic main_osc_en,
    input wire logic adc_start,
    input wire logic cpu_stall,
    input wire logic wake_irq,
    input wire logic wake_reset,
    input wire logic sleeping
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ENTRY: assert property ($rose(sleeping) |-> $past(sleep_instr))
        else $error("sleep entered without opcode");
    AST_STALL: assert property (sleeping |-> cpu_stall)
        else $error("core not stalled while asleep");
    AST_IRQ_END: assert property (wake_irq |-> !sleeping && !cpu_stall ##1 !wake_irq)
        else $error("irq wake pulse wrong");
    AST_RST_PULSE: assert property (wake_reset |-> !sleeping ##1 !wake_reset)
        else $error("reset wake pulse wrong");
    AST_CPU_GATE: assert property (sleeping |-> !cpu_clock_domain && !flash_clock_domain)
        else $error("core clocks run in sleep");
    AST_IO_IDLE: assert property (sleeping && io_clock_domain |-> converter_clock_domain && main_osc_en)
        else $error("io clock outside idle");
    AST_DOWN: assert property (sleeping && !main_osc_en |-> !io_clock_domain && !converter_clock_domain)
        else $error("clocks run with oscillator off");
    AST_ADC_KICK: assert property (adc_start |-> $rose(sleeping) && converter_clock_domain)
        else $error("conversion start out of place");
    AST_RESTART: assert property ($fell(sleeping) |-> cpu_stall)
        else $error("no start-up stall on wake");
    cover property ($rose(sleeping));
    cover property (wake_irq);
    cover property (wake_reset);
endmodule
bind sleep_mode_controller sleep_mode_controller_sva i_sva (.pclk, .presetn, .sleep_instr, .cpu_clock_domain,
    .flash_clock_domain, .io_clock_domain, .converter_clock_domain, .main_osc_en, .adc_start, .cpu_stall,
    .wake_irq, .wake_reset, .sleeping);

// *** testbench/sleep_mode_controller_tb.sv ***
`timescale 1ns/1ps
module sleep_mode_controller_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, rst_req, adc_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] lo, hi, dly;
    logic [1:0] ssel, tmask;
    logic gie, t0ovf, cken, adc_clr;
    logic [5:0] clk_now;
    logic sleep_instr, adcs, stall, wirq, wrst, slp;
    int num_errors = 0;
    int tests_run = 0;
    sleep_mode_controller i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_en(cken), .sleep_instr(sleep_instr), .sys_reset_req(rst_req), .global_irq_en(gie),
        .ext_irq_lower(lo), .ext_irq_upper(hi), .twi_addr_match(1'b0), .timer0_ovf_irq(t0ovf),
        .timer0_cmp_irq(1'b0), .timer_irq_mask(tmask), .adc_done_irq(1'b0), .spm_ready_irq(1'b0),
        .other_io_irq(1'b0), .startup_sel(ssel), .cpu_clock_domain(clk_now[5]), .flash_clock_domain(clk_now[4]),
        .io_clock_domain(clk_now[3]), .converter_clock_domain(clk_now[2]), .async_clock_domain(clk_now[1]),
        .main_osc_en(clk_now[0]), .timer_osc_en(), .comparator_power(), .adc_start(adcs), .cpu_stall(stall),
        .wake_irq(wirq), .wake_reset(wrst), .sleeping(slp));
    sleep_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .go(go), .delay(dly), .sleep_instr(sleep_instr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // the conversion strobe lasts one cycle, so it is latched for a later look
    always @(posedge pclk) adc_seen <= adc_clr ? 1'b0 : (adc_seen | adcs);
    task automatic finish_test;
        $display("mismatches %0d of %0d compares", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        @(posedge pclk);
    endtask
    function automatic logic [31:0] ctl(input logic se, input logic [2:0] m);
        logic [31:0] v;
        v = 32'h0;
        v[sleep_ctrl_pkg::SE_POS] = se;
        v[sleep_ctrl_pkg::SM1_POS] = m[1];
        v[sleep_ctrl_pkg::SM0_POS] = m[0];
        v[sleep_ctrl_pkg::SM2_POS] = m[2];
        return v;
    endfunction
    // count edges until the chosen output reaches v; a wait that runs out counts as a mismatch
    task automatic hold(input int sel, input logic v, output int n);
        n = 0;
        while ((sel == 0 ? slp : sel == 1 ? wirq : wrst) !== v && n < 60) begin @(posedge pclk); n++; end
        if (n >= 60) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic regs_check;
        apb(0, sleep_ctrl_pkg::ADDR_CONTROL, 32'h0); chk(rd, 32'h0);
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, 32'hFFFF_FFFF);
        apb(0, sleep_ctrl_pkg::ADDR_CONTROL, 32'h0); chk(rd, 32'h0000_00FF);
        apb(1, 12'h00C, 32'h0000_00FF);
        apb(0, 12'h00C, 32'h0); chk(rd, 32'h0);
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, ctl(1'b0, 3'b010));
    endtask
    task automatic no_enable;
        go <= 1'b1; dly <= 4'h2;
        @(posedge pclk) go <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(slp, 1'b0);
    endtask
    task automatic run_mode(input logic [2:0] m, input logic xt, input logic rs);
        logic [2:0] e;
        logic [5:0] ce;
        int n;
        e = (m[2] && !m[1]) ? 3'b000 : (m[2] && !xt) ? {1'b0, m[1:0]} : m;
        case (e)
            3'b000: ce = 6'h0F;
            3'b001: ce = 6'h07;
            3'b110, 3'b111: ce = 6'h01;
            default: ce = 6'h00;
        endcase
        apb(1, sleep_ctrl_pkg::ADDR_AUX, {28'h0, xt, 3'b100});
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, ctl(1'b1, m));
        adc_clr <= 1'b1; go <= 1'b1; dly <= {3'h0, xt};
        @(posedge pclk) go <= 1'b0;
        adc_clr <= 1'b0;
        hold(0, 1'b1, n);
        @(posedge pclk);
        chk({26'h0, clk_now}, {26'h0, ce});
        chk(adc_seen, !e[1]);
        if (rs) rst_req <= 1'b1;
        else begin lo <= {3'h0, !m[0]}; hi <= {m[0], 3'h0}; end
        hold(0, 1'b0, n);
        rst_req <= 1'b0; lo <= 4'h0; hi <= 4'h0;
        hold(rs ? 2 : 1, 1'b1, n);
        chk(n, rs ? (ssel == 2'h0 ? 6 : 18) : (e[1] ? 10 : 4));
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, 32'h0);
    endtask
    // power-save with the async timer: frozen while clock enable is low, then the timer wakes it
    task automatic timer_wake;
        int n;
        apb(1, sleep_ctrl_pkg::ADDR_AUX, 32'h0000_0009);
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, ctl(1'b1, 3'b011));
        gie <= 1'b1; tmask <= 2'h1; go <= 1'b1; dly <= 4'h0;
        @(posedge pclk) go <= 1'b0;
        hold(0, 1'b1, n);
        chk({26'h0, clk_now}, 32'h0000_0002);
        cken <= 1'b0; t0ovf <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(slp, 1'b1);
        cken <= 1'b1;
        hold(0, 1'b0, n);
        t0ovf <= 1'b0;
        hold(1, 1'b1, n);
        chk(n, 10);
        gie <= 1'b0; tmask <= 2'h0;
        apb(1, sleep_ctrl_pkg::ADDR_CONTROL, 32'h0);
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        go = 1'b0; dly = 4'h0; rst_req = 1'b0; lo = 4'h0; hi = 4'h0; ssel = 2'h0; adc_clr = 1'b0;
        gie = 1'b0; t0ovf = 1'b0; cken = 1'b1; tmask = 2'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_check();
        no_enable();
        for (int i = 0; i < 8; i++) run_mode(i[2:0], 1'b1, 1'b0);
        run_mode(3'b110, 1'b0, 1'b0);
        run_mode(3'b111, 1'b0, 1'b0);
        timer_wake();
        ssel <= 2'h1;
        run_mode(3'b010, 1'b1, 1'b1);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        finish_test();
    end
endmodule
